/* rtl/pac_defs.svh */
// Register offsets, field positions, reset values and timing counts for the accumulator block
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH
`define PAC_CTRL_OFS 8'h20
`define PAC_FLAG_OFS 8'h21
`define PAC_CNT_OFS 8'h22
`define PAC_TSC_OFS 8'h24
`define PAC_CTRL_RST 8'h00
`define PAC_CTRL_MASK 8'h7f
`define PAC_BIT_EN 6
`define PAC_BIT_MODE 5
`define PAC_BIT_EDGE 4
`define PAC_BIT_CLKHI 3
`define PAC_BIT_CLKLO 2
`define PAC_BIT_OVI 1
`define PAC_BIT_INI 0
`define PAC_BIT_OVF 1
`define PAC_BIT_INF 0
`define PAC_BIT_TEN 7
`define PAC_BIT_FFCA 4
`define PAC_DIV64 6'h3f
`define PAC_DIV256 8'hff
`endif

/* rtl/pac_edge_if.sv */
// Signals between the pin edge detector and the control logic
interface pac_edge_if;
  logic pin_level;
  logic rise;
  logic fall;
  modport det (output pin_level, output rise, output fall);
  modport ctl (input pin_level, input rise, input fall);
endinterface : pac_edge_if

/* rtl/pac_pin_sync.sv */
// Pin synchroniser and edge detector for the channel 7 pin
module pac_pin_sync (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  pac_edge_if.det edge_o
);
  logic meta;
  logic sync;
  logic last;
  // The second stage and its delayed copy in the third stage feed the edge logic
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= i_pin;
      sync <= meta;
      last <= sync;
    end
  end
  assign edge_o.pin_level = sync;
  assign edge_o.rise = sync & ~last;
  assign edge_o.fall = ~sync & last;
endmodule : pac_pin_sync

/* rtl/pac_pkg.sv */
// Types shared by the accumulator control block
package pac_pkg;
  typedef enum logic [1:0] {
    PAC_CLK_PRESCALE = 2'b00,
    PAC_CLK_ACCUM = 2'b01,
    PAC_CLK_DIV256 = 2'b10,
    PAC_CLK_DIV65536 = 2'b11
  } pac_clk_sel_t;
  typedef enum logic [1:0] {
    PAC_ST_IDLE = 2'b00,
    PAC_ST_ACCESS = 2'b01
  } pac_apb_st_t;
endpackage : pac_pkg

/* rtl/pac_top.sv */
// Pulse accumulator control, flags and count with an APB register slave
//
// The APB register port was decided locally.
`include "pac_defs.svh"

// Summary of operation
// - Counter runs only while accumulator enable set
// - Event counting works with timer disabled
// - Mode bit picks event or gated counting
// - Edge bit picks falling or rising edge
// - Gated level passes div64; trailing edge flags
// - Div64 tick only while timer enabled
// - Clock select picks counter clock source
// - Disabled accumulator forces prescaler clock
// - Clock select change takes effect at once
// - Overflow flag requests irq when enabled
// - Input flag requests irq when enabled
// - Overflow flag on count wrap to zero
// - Input flag on counted or trailing edge
// - Write one clears flag when enabled
// - Fast clear: count access clears flags
// - No channel 7: control, flags read zero
// - Count register holds counted edges or gated div64 ticks
// - Pin synchronised before counting
module pac_top import pac_pkg::*; #(
  parameter bit HAS_CH7 = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_channel7_pin,
  input wire logic i_prescale_tick,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_timer_clk_tick,
  output logic o_overflow_irq,
  output logic o_input_irq,
  output logic o_timer_enable,
  output logic o_fast_flag_clear
);
  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] accum_control_reg;
  logic [1:0] accum_flag_reg;
  logic [15:0] accum_count;
  logic [7:0] timer_system_control1;
  logic [5:0] div64_cnt;
  logic [7:0] div256_cnt;
  logic [7:0] div65536_cnt;
  pac_apb_st_t apb_st;
  pac_edge_if edge_bus ();

  pac_pin_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_channel7_pin),
    .edge_o(edge_bus)
  );

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  logic accum_enable;
  logic accum_mode_select;
  logic accum_edge_select;
  logic timer_enable;
  logic fast_flag_clear;
  pac_clk_sel_t clk_sel;
  assign accum_enable = accum_control_reg[`PAC_BIT_EN];
  assign accum_mode_select = accum_control_reg[`PAC_BIT_MODE];
  assign accum_edge_select = accum_control_reg[`PAC_BIT_EDGE];
  assign clk_sel = pac_clk_sel_t'(accum_control_reg[`PAC_BIT_CLKHI:`PAC_BIT_CLKLO]);
  assign timer_enable = timer_system_control1[`PAC_BIT_TEN];
  assign fast_flag_clear = timer_system_control1[`PAC_BIT_FFCA];

  // ****************************************
  // APB handshake
  // ****************************************
  // No wait state: setup, access with pready high, so every access takes two cycles
  logic acc_done;
  logic wr_en;
  logic rd_en;
  assign acc_done = i_psel & i_penable & o_pready;
  assign wr_en = acc_done & i_pwrite;
  assign rd_en = acc_done & ~i_pwrite;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      apb_st <= PAC_ST_IDLE;
      o_pready <= 1'b0;
    end else begin
      unique case (apb_st)
        PAC_ST_IDLE: begin
          o_pready <= 1'b0;
          if (i_psel & ~i_penable) begin
            apb_st <= PAC_ST_ACCESS;
            o_pready <= 1'b1;
          end
        end
        PAC_ST_ACCESS: begin
          if (acc_done) begin
            apb_st <= PAC_ST_IDLE;
            o_pready <= 1'b0;
          end
        end
        default: begin
          apb_st <= PAC_ST_IDLE;
          o_pready <= 1'b0;
        end
      endcase
    end
  end

  // Unmapped offsets answer normally but raise the error flag and change nothing
  logic mapped;
  assign mapped = addr_hit(i_paddr, `PAC_CTRL_OFS) | addr_hit(i_paddr, `PAC_FLAG_OFS) |
                  addr_hit(i_paddr, `PAC_CNT_OFS) | addr_hit(i_paddr, `PAC_TSC_OFS);

  // ****************************************
  // Timer system control (enable, fast clear)
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      timer_system_control1 <= 8'h00;
    end else if (wr_en & addr_hit(i_paddr, `PAC_TSC_OFS)) begin
      timer_system_control1 <= i_pwdata[7:0] & 8'h90;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      accum_control_reg <= `PAC_CTRL_RST;
    end else if (HAS_CH7 & wr_en & addr_hit(i_paddr, `PAC_CTRL_OFS)) begin
      accum_control_reg <= i_pwdata[7:0] & `PAC_CTRL_MASK;
    end
  end

  // ****************************************
  // Tick generation and counting
  // ****************************************
  // Div64 counts reference clocks only while the timer is enabled, so it stops with the timer
  logic div64_tick;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      div64_cnt <= 6'h00;
    end else if (timer_enable) begin
      div64_cnt <= div64_cnt + 6'h01;
    end
  end
  assign div64_tick = timer_enable & (div64_cnt == `PAC_DIV64);

  logic gate_active;
  logic count_tick;
  logic trail_edge;
  // Gate level and counted edge both use the synchronised pin, never the raw input
  assign gate_active = accum_edge_select ? ~edge_bus.pin_level : edge_bus.pin_level;
  assign trail_edge = accum_edge_select ? edge_bus.rise : edge_bus.fall;
  always_comb begin
    count_tick = 1'b0;
    if (accum_enable) begin
      if (accum_mode_select) begin
        count_tick = gate_active & div64_tick;
      end else begin
        count_tick = trail_edge;
      end
    end
  end

  logic cnt_access;
  logic cnt_wr;
  assign cnt_access = HAS_CH7 & (wr_en | rd_en) & addr_hit(i_paddr, `PAC_CNT_OFS);
  assign cnt_wr = cnt_access & i_pwrite;

  // Wrap comes from a real tick, so loading 0xffff alone raises no flag
  logic wrap;
  assign wrap = count_tick & (accum_count == 16'hffff);
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      accum_count <= 16'h0000;
    end else if (cnt_wr) begin
      accum_count <= i_pwdata[15:0];
    end else if (count_tick) begin
      accum_count <= accum_count + 16'h0001;
    end
  end

  // ****************************************
  // Timer counter clock selection
  // ****************************************
  // Div256 advances on every accumulator clock and div65536 on its carry; neither is realigned on a select change
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      div256_cnt <= 8'h00;
      div65536_cnt <= 8'h00;
    end else if (count_tick) begin
      div256_cnt <= div256_cnt + 8'h01;
      if (div256_cnt == `PAC_DIV256) begin
        div65536_cnt <= div65536_cnt + 8'h01;
      end
    end
  end

  // Selection is combinational, so a new value applies on the next edge
  logic next_timer_clk_tick;
  always_comb begin
    next_timer_clk_tick = i_prescale_tick;
    if (accum_enable) begin
      unique case (clk_sel)
        PAC_CLK_PRESCALE: next_timer_clk_tick = i_prescale_tick;
        PAC_CLK_ACCUM: next_timer_clk_tick = count_tick;
        PAC_CLK_DIV256: next_timer_clk_tick = count_tick & (div256_cnt == `PAC_DIV256);
        PAC_CLK_DIV65536: next_timer_clk_tick = count_tick & (div256_cnt == `PAC_DIV256) &
                                                (div65536_cnt == `PAC_DIV256);
      endcase
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  logic clr_allowed;
  logic [1:0] clr_mask;
  logic [1:0] set_mask;
  assign clr_allowed = timer_enable | accum_enable;
  // Clears act on the completing access only, never on a bare setup cycle
  always_comb begin
    clr_mask = 2'b00;
    if (clr_allowed & HAS_CH7 & wr_en & addr_hit(i_paddr, `PAC_FLAG_OFS)) begin
      clr_mask = i_pwdata[1:0];
    end
    if (clr_allowed & fast_flag_clear & cnt_access) begin
      clr_mask = 2'b11;
    end
  end
  assign set_mask = {wrap, accum_enable & trail_edge};

  // A set in the same cycle as a clear wins
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      accum_flag_reg <= 2'b00;
    end else begin
      accum_flag_reg <= (accum_flag_reg & ~clr_mask) | set_mask;
    end
  end

  // ****************************************
  // Outputs and read data
  // ****************************************
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (HAS_CH7 & addr_hit(i_paddr, `PAC_CTRL_OFS)) begin
      next_prdata = {24'h00_0000, accum_control_reg};
    end else if (HAS_CH7 & addr_hit(i_paddr, `PAC_FLAG_OFS)) begin
      next_prdata = {30'h0000_0000, accum_flag_reg};
    end else if (HAS_CH7 & addr_hit(i_paddr, `PAC_CNT_OFS)) begin
      next_prdata = {16'h0000, accum_count};
    end else if (addr_hit(i_paddr, `PAC_TSC_OFS)) begin
      next_prdata = {24'h00_0000, timer_system_control1};
    end
  end

  // Read data and error are taken at setup and stand through the access phase
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_psel & ~i_penable) begin
      o_prdata <= i_pwrite ? 32'h0000_0000 : next_prdata;
      o_pslverr <= ~mapped;
    end
  end

  // Requests follow the flags one cycle late, as every output is registered
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_timer_clk_tick <= 1'b0;
      o_overflow_irq <= 1'b0;
      o_input_irq <= 1'b0;
      o_timer_enable <= 1'b0;
      o_fast_flag_clear <= 1'b0;
    end else begin
      o_timer_clk_tick <= next_timer_clk_tick;
      o_overflow_irq <= accum_control_reg[`PAC_BIT_OVI] & accum_flag_reg[`PAC_BIT_OVF];
      o_input_irq <= accum_control_reg[`PAC_BIT_INI] & accum_flag_reg[`PAC_BIT_INF];
      o_timer_enable <= timer_enable;
      o_fast_flag_clear <= fast_flag_clear;
    end
  end
endmodule : pac_top

/* tb/pac_pin_model.sv */
// Pulse source on the channel 7 pin
module pac_pin_model (
  input wire logic i_ref_clk,
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_pin = 1'b0;
  // Edges 8 clocks apart, so the synchroniser never merges two
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (8) @(posedge i_ref_clk);
      o_pin <= ~o_pin;
    end
  endtask : toggle
  task automatic level(input logic v, input int cyc);
    @(posedge i_ref_clk);
    o_pin <= v;
    repeat (cyc) @(posedge i_ref_clk);
  endtask : level
endmodule : pac_pin_model

/* tb/pac_top_asserts.sv */
// Port-level checks for the accumulator block
`include "pac_defs.svh"
module pac_top_asserts (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_prescale_tick,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_timer_clk_tick,
  input wire logic o_overflow_irq,
  input wire logic o_input_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] sh_ctrl;
  wire mapped = i_paddr inside {8'h20, 8'h21, 8'h22, 8'h24};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Control shadow, updated at the same edge as the real register
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sh_ctrl <= 7'h00;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `PAC_CTRL_OFS) begin
      sh_ctrl <= i_pwdata[6:0];
    end
  end
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_read(a);
    i_psel && i_penable && o_pready && !i_pwrite && i_paddr == a;
  endsequence
  AST_PREADY: assert property (s_setup |=> o_pready && i_penable)
    else $error("no ready after setup");
  AST_SINGLE: assert property (o_pready |=> !o_pready)
    else $error("ready held two cycles");
  AST_UNMAP: assert property (s_setup |=> o_pslverr == !$past(mapped))
    else $error("slave error wrong");
  AST_CTRL_RD: assert property (s_read(`PAC_CTRL_OFS) |-> o_prdata == {25'h0, sh_ctrl})
    else $error("control read wrong");
  AST_FLAG_RD: assert property (s_read(`PAC_FLAG_OFS) |-> o_prdata[31:2] == 30'h0)
    else $error("flag read high bits set");
  AST_OVI: assert property ((!sh_ctrl[1]) [*2] |=> !o_overflow_irq)
    else $error("overflow irq not masked");
  AST_INI: assert property ((!sh_ctrl[0]) [*2] |=> !o_input_irq)
    else $error("input irq not masked");
  AST_CLK_OFF: assert property ((!sh_ctrl[6]) [*2] |-> o_timer_clk_tick == $past(i_prescale_tick))
    else $error("disabled clock not prescaler");
  AST_CLK_PRE: assert property ((sh_ctrl[3:2] == 2'b00) [*2] |-> o_timer_clk_tick == $past(i_prescale_tick))
    else $error("select 00 not prescaler");
endmodule : pac_top_asserts

bind pac_top pac_top_asserts chk_u (
  .i_ref_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .i_prescale_tick, .o_prdata, .o_pready, .o_pslverr, .o_timer_clk_tick,
  .o_overflow_irq, .o_input_irq
);

/* tb/pac_top_bench.sv */
// Self-checking bench for the accumulator block
`include "pac_defs.svh"
module pac_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pre_tick, pin, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, tick, ov_irq, in_irq, ten_o, ffc_o;
  logic [1:0] pcnt;
  int miscompares, n_checks, ticks, t0;
  pac_top dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_channel7_pin(pin),
    .i_prescale_tick(pre_tick), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_timer_clk_tick(tick), .o_overflow_irq(ov_irq), .o_input_irq(in_irq),
    .o_timer_enable(ten_o), .o_fast_flag_clear(ffc_o));
  pac_pin_model pin_u (.i_ref_clk(clk), .o_pin(pin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Prescaler stand-in: one tick every fourth clock
  always @(posedge clk) begin
    if (rst) begin
      pcnt <= 2'h0;
      pre_tick <= 1'b0;
      ticks <= 0;
    end else begin
      pcnt <= pcnt + 2'h1;
      pre_tick <= (pcnt == 2'h3);
      if (tick === 1'b1) ticks <= ticks + 1;
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Bounded wait for ready; a hang ends the run
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("mismatch ready exp 1 got 0");
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  task automatic t_regs();
    rdc("ctrl", `PAC_CTRL_OFS, 32'h0);
    rdc("flags", `PAC_FLAG_OFS, 32'h0);
    wr(`PAC_CTRL_OFS, 32'hff);
    rdc("ctrl", `PAC_CTRL_OFS, 32'h7f);
    wr(`PAC_CTRL_OFS, 32'h0c);
    apb(8'h30, 1'b0, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("regs done");
  endtask : t_regs
  // Three toggles give two edges of the chosen kind; timer stays off
  task automatic t_event();
    for (int e = 1; e >= 0; e--) begin
      wr(`PAC_CTRL_OFS, 32'h41 | (e << 4));
      wr(`PAC_CNT_OFS, 32'h0);
      wr(`PAC_FLAG_OFS, 32'h3);
      pin_u.toggle(3);
      repeat (6) @(posedge clk);
      rdc("count", `PAC_CNT_OFS, 32'h2);
      rdc("flags", `PAC_FLAG_OFS, 32'h1);
      chk("in_irq", 32'h1, {31'h0, in_irq});
      wr(`PAC_FLAG_OFS, 32'h1);
      rdc("flags", `PAC_FLAG_OFS, 32'h0);
      chk("in_irq", 32'h0, {31'h0, in_irq});
    end
    $display("event done");
  endtask : t_event
  task automatic t_ovf();
    wr(`PAC_CTRL_OFS, 32'h52);
    wr(`PAC_CNT_OFS, 32'hffff);
    pin_u.toggle(2);
    repeat (6) @(posedge clk);
    rdc("count", `PAC_CNT_OFS, 32'h0);
    chk("ov_irq", 32'h1, {31'h0, ov_irq});
    wr(`PAC_CTRL_OFS, 32'h0);
    wr(`PAC_FLAG_OFS, 32'h3);
    rdc("flags", `PAC_FLAG_OFS, 32'h3);
    wr(`PAC_TSC_OFS, 32'h90);
    rdc("count", `PAC_CNT_OFS, 32'h0);
    chk("ten", 32'h1, {31'h0, ten_o});
    chk("ffca", 32'h1, {31'h0, ffc_o});
    rdc("flags", `PAC_FLAG_OFS, 32'h0);
    $display("overflow done");
  endtask : t_ovf
  // 640 gated cycles hold exactly ten div64 ticks whatever the phase with the timer on, none with it off
  task automatic t_gated();
    wr(`PAC_TSC_OFS, 32'h80);
    pin_u.level(1'b1, 4);
    wr(`PAC_CTRL_OFS, 32'h70);
    wr(`PAC_CNT_OFS, 32'h0);
    wr(`PAC_FLAG_OFS, 32'h3);
    pin_u.level(1'b0, 639);
    pin_u.level(1'b1, 8);
    rdc("gated low", `PAC_CNT_OFS, 32'd10);
    rdc("glflag", `PAC_FLAG_OFS, 32'h1);
    pin_u.level(1'b0, 8);
    for (int t = 1; t >= 0; t--) begin
      wr(`PAC_CTRL_OFS, 32'h60);
      wr(`PAC_CNT_OFS, 32'h0);
      wr(`PAC_FLAG_OFS, 32'h3);
      pin_u.level(1'b1, 639);
      pin_u.level(1'b0, 8);
      rdc("gated", `PAC_CNT_OFS, 32'd10 * t);
      if (t == 1) rdc("gflag", `PAC_FLAG_OFS, 32'h1);
      wr(`PAC_TSC_OFS, 32'h0);
    end
    $display("gated done");
  endtask : t_gated
  task automatic t_clk();
    wr(`PAC_CTRL_OFS, 32'h54);
    repeat (2) @(posedge clk);
    t0 = ticks;
    pin_u.toggle(2);
    repeat (6) @(posedge clk);
    chk("acc ticks", 32'h1, ticks - t0);
    wr(`PAC_CTRL_OFS, 32'h58);
    repeat (2) @(posedge clk);
    t0 = ticks;
    pin_u.toggle(512);
    repeat (6) @(posedge clk);
    chk("div256 ticks", 32'h1, ticks - t0);
    wr(`PAC_CTRL_OFS, 32'h0);
    $display("clock select done");
  endtask : t_clk
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_event();
    t_ovf();
    t_gated();
    t_clk();
    stop_test();
  end
endmodule : pac_top_bench
